// ### hdl/relay_cmd_pkg.sv
// constants shared by the relay pattern command engine
package relay_cmd_pkg;
   // byte framing
   localparam int BYTE_W = 8;
   localparam logic [7:0] PREFIX_BYTE = 8'hfe;
   localparam logic [7:0] BRANCH_BYTE = 8'h0e;
   localparam logic [7:0] ECHO_BYTE = 8'h55;
   // command codes
   localparam logic [7:0] CMD_INVERT = 8'h1f;
   localparam logic [7:0] CMD_REVERSE = 8'h20;
   localparam logic [7:0] CMD_LINK_TEST = 8'h21;
   localparam logic [7:0] CMD_LOAD = 8'h28;
   localparam logic [7:0] CMD_UNSUPPORTED = 8'h29;
   localparam logic [7:0] CMD_STORE = 8'h2a;
   localparam logic [7:0] CMD_RECALL = 8'h2b;
   localparam logic [7:0] CMD_SELECT = 8'h2c;
   localparam logic [7:0] CMD_DESELECT = 8'h2d;
   localparam logic [7:0] CMD_TOGGLE = 8'h2e;
   localparam logic [7:0] CMD_TIMED_ONE = 8'h2f;
   localparam logic [7:0] CMD_TIMED_PATTERN = 8'h30;
   // time byte fields
   localparam int FEEDBACK_BIT = 7;
   localparam int STEP_BIT = 6;
   localparam int DURATION_W = 6;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BASE_STEP_MS = 10;
   localparam int LONG_STEP_MS = 500;
   localparam int BASE_STEP_CYCLES = BASE_STEP_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [11:0] LONG_STEP_TICKS = 12'(LONG_STEP_MS / BASE_STEP_MS);
   // register port
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic CTRL_ENABLE_RST = 1'b1;
   localparam logic [7:0] RELAY_RST = 8'h00;
   localparam int BANKS = 16;
endpackage : relay_cmd_pkg

// ### hdl/relay_pattern_command_engine.sv
// byte command interpreter driving an 8-relay bank with pattern memory and timers
//
// How it works
// - link characters are eight data bits, one stop bit, no parity
// - code 31 complements every relay bit
// - code 32 mirrors relay bit order, copying states only
// - code 33 sends byte 85 back to the host
// - code 40 loads its parameter byte straight into the relays
// - code 41 does nothing and waits for a new command
// - code 42 saves the relay pattern in memory slot 0 to 15
// - code 43 drives relays from the pattern saved in a slot
// - code 44 turns all relays off, then turns the chosen one on
// - code 45 turns all relays on, then turns the chosen one off
// - code 46 inverts one chosen relay
// - timed periods span 10 ms to 32 s within 5 percent
// - time bit 128 makes the device send 85 when the timer ends
// - time bit 64 picks 0.5 s steps instead of 10 ms steps
// - code 47 turns one relay on for the period, others untouched
// - code 47 on a relay already on has no effect
// - code 48 applies start pattern, waits, then applies end pattern
// - every byte arriving while a timer runs is discarded
`timescale 1ns/100ps
`default_nettype none
module relay_pattern_command_engine import relay_cmd_pkg::*; #(
   parameter int TICK_CYCLES = BASE_STEP_CYCLES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // received byte stream from the serial receiver
   input wire logic [relay_cmd_pkg::BYTE_W-1:0] i_rx_data,
   input wire logic i_rx_valid,
   // reply byte to the serial transmitter
   output logic [relay_cmd_pkg::BYTE_W-1:0] o_tx_data,
   output logic o_tx_valid,
   // relay drive
   output logic [7:0] o_relay,
   output logic o_busy,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata
);
   import relay_cmd_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_BRANCH = 3'b001,
      ST_CMD = 3'b010,
      ST_P1 = 3'b011,
      ST_P2 = 3'b100,
      ST_P3 = 3'b101,
      ST_SEL = 3'b110,
      ST_TIME = 3'b111
   } state_e;

   typedef struct packed {
      state_e st;
      logic en;
      logic [7:0] cmd;
      logic [7:0] tbyte;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] relay;
      logic [BANKS-1:0][7:0] mem;
      logic [31:0] div;
      logic [11:0] ticks;
      logic [7:0] tx_data;
      logic tx_valid;
      logic busy;
      logic [31:0] rdata;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic tick;
   logic take;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : rev8

   // period in base steps: (duration + 1) times the step size
   function automatic logic [11:0] ticks_of(input logic [7:0] tb);
      logic [11:0] n;
      n = 12'(tb[DURATION_W-1:0]) + 12'h001;
      if (tb[STEP_BIT]) begin
         n = 12'(n * LONG_STEP_TICKS);
      end
      return n;
   endfunction : ticks_of

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.tx_valid = 1'b0;
      s_d.rdata = '0;
      tick = 1'b0;
      // bytes are dropped while disabled, timing or mid select
      take = i_rx_valid && s_q.en && (s_q.st != ST_TIME) && (s_q.st != ST_SEL);

      // register port
      if (i_reg_wr && i_reg_addr == REG_CTRL) begin
         s_d.en = i_reg_wdata[0];
      end
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            REG_CTRL: s_d.rdata = {31'h0, s_q.en};
            REG_STATUS: s_d.rdata = {23'h0, s_q.st == ST_TIME, s_q.relay};
            default: s_d.rdata = '0;
         endcase
      end

      // timer: divider restarts at each start so the first step is full
      if (s_q.st == ST_TIME) begin
         if (s_q.div == 32'(TICK_CYCLES - 1)) begin
            s_d.div = '0;
            tick = 1'b1;
         end else begin
            s_d.div = s_q.div + 32'h1;
         end
         if (tick) begin
            if (s_q.ticks == 12'h001) begin
               if (s_q.cmd == CMD_TIMED_ONE) begin
                  s_d.relay[s_q.p2[2:0]] = 1'b0;
               end else begin
                  s_d.relay = s_q.p2;
               end
               if (s_q.tbyte[FEEDBACK_BIT]) begin
                  s_d.tx_data = ECHO_BYTE;
                  s_d.tx_valid = 1'b1;
               end
               s_d.st = ST_IDLE;
            end else begin
               s_d.ticks = s_q.ticks - 12'h001;
            end
         end
      end

      // second half of break-before-make / make-before-break
      if (s_q.st == ST_SEL) begin
         s_d.relay[s_q.p1[2:0]] = (s_q.cmd == CMD_SELECT);
         s_d.st = ST_IDLE;
      end

      if (take) begin
         unique case (s_q.st)
            ST_IDLE: begin
               if (i_rx_data == PREFIX_BYTE) begin
                  s_d.st = ST_BRANCH;
               end
            end
            ST_BRANCH: begin
               if (i_rx_data == BRANCH_BYTE) begin
                  s_d.st = ST_CMD;
               end else if (i_rx_data != PREFIX_BYTE) begin
                  s_d.st = ST_IDLE;
               end
            end
            ST_CMD: begin
               s_d.cmd = i_rx_data;
               s_d.st = ST_IDLE;
               unique case (i_rx_data)
                  CMD_INVERT: s_d.relay = ~s_q.relay;
                  CMD_REVERSE: s_d.relay = rev8(s_q.relay);
                  CMD_LINK_TEST: begin
                     s_d.tx_data = ECHO_BYTE;
                     s_d.tx_valid = 1'b1;
                  end
                  CMD_LOAD, CMD_STORE, CMD_RECALL, CMD_SELECT, CMD_DESELECT,
                  CMD_TOGGLE, CMD_TIMED_ONE, CMD_TIMED_PATTERN: s_d.st = ST_P1;
                  default: s_d.st = ST_IDLE;
               endcase
            end
            ST_P1: begin
               s_d.p1 = i_rx_data;
               s_d.st = ST_IDLE;
               unique case (s_q.cmd)
                  CMD_LOAD: s_d.relay = i_rx_data;
                  CMD_STORE: s_d.mem[i_rx_data[3:0]] = s_q.relay;
                  CMD_RECALL: s_d.relay = s_q.mem[i_rx_data[3:0]];
                  CMD_SELECT: begin
                     s_d.relay = 8'h00;
                     s_d.st = ST_SEL;
                  end
                  CMD_DESELECT: begin
                     s_d.relay = 8'hff;
                     s_d.st = ST_SEL;
                  end
                  CMD_TOGGLE: s_d.relay[i_rx_data[2:0]] = ~s_q.relay[i_rx_data[2:0]];
                  default: begin
                     s_d.tbyte = i_rx_data;
                     s_d.st = ST_P2;
                  end
               endcase
            end
            ST_P2: begin
               s_d.p2 = i_rx_data;
               if (s_q.cmd == CMD_TIMED_ONE) begin
                  if (s_q.relay[i_rx_data[2:0]]) begin
                     s_d.st = ST_IDLE;
                  end else begin
                     s_d.relay[i_rx_data[2:0]] = 1'b1;
                     s_d.ticks = ticks_of(s_q.tbyte);
                     s_d.div = '0;
                     s_d.st = ST_TIME;
                  end
               end else begin
                  s_d.st = ST_P3;
               end
            end
            ST_P3: begin
               s_d.relay = s_q.p2;
               s_d.p2 = i_rx_data;
               s_d.ticks = ticks_of(s_q.tbyte);
               s_d.div = '0;
               s_d.st = ST_TIME;
            end
            default: s_d.st = s_q.st;
         endcase
      end
      // busy kept as its own flop so the pin is registered
      s_d.busy = (s_d.st == ST_TIME);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_q <= '0;
         s_q.en <= CTRL_ENABLE_RST;
         s_q.relay <= RELAY_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_relay = s_q.relay;
   assign o_tx_data = s_q.tx_data;
   assign o_tx_valid = s_q.tx_valid;
   assign o_busy = s_q.busy;
   assign o_reg_rdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   property p_invert;
      take && s_q.st == ST_CMD && i_rx_data == CMD_INVERT |=> o_relay == ~$past(o_relay);
   endproperty
   a_invert: assert property (p_invert) else $error("invert wrong");

   property p_reverse;
      take && s_q.st == ST_CMD && i_rx_data == CMD_REVERSE |=> o_relay == rev8($past(o_relay));
   endproperty
   a_reverse: assert property (p_reverse) else $error("reverse wrong");

   property p_echo;
      take && s_q.st == ST_CMD && i_rx_data == CMD_LINK_TEST
         |=> o_tx_valid && o_tx_data == ECHO_BYTE ##1 !o_tx_valid;
   endproperty
   a_echo: assert property (p_echo) else $error("link test reply wrong");

   property p_load;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_LOAD |=> o_relay == $past(i_rx_data);
   endproperty
   a_load: assert property (p_load) else $error("pattern load wrong");

   property p_select;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_SELECT
         |=> o_relay == 8'h00 ##1 o_relay == (8'h01 << $past(i_rx_data[2:0], 2));
   endproperty
   a_select: assert property (p_select) else $error("select sequence wrong");

   property p_toggle;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_TOGGLE
         |=> o_relay == ($past(o_relay) ^ (8'h01 << $past(i_rx_data[2:0])));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle wrong");

   property p_period;
      $rose(o_busy) |-> s_q.ticks == ticks_of(s_q.tbyte) && s_q.div == 32'h0;
   endproperty
   a_period: assert property (p_period) else $error("period load wrong");

   property p_feedback;
      o_busy && tick && s_q.ticks == 12'h001
         |=> !o_busy && (o_tx_valid == $past(s_q.tbyte[FEEDBACK_BIT]));
   endproperty
   a_feedback: assert property (p_feedback) else $error("feedback wrong");

   property p_already_on;
      take && s_q.st == ST_P2 && s_q.cmd == CMD_TIMED_ONE && s_q.relay[i_rx_data[2:0]]
         |=> !o_busy && o_relay == $past(o_relay);
   endproperty
   a_already_on: assert property (p_already_on) else $error("timer on lit relay");

   property p_busy_hold;
      o_busy && !tick |=> o_relay == $past(o_relay) && !o_tx_valid;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("acted while timing");

   property p_stray;
      take && s_q.st == ST_IDLE && i_rx_data != PREFIX_BYTE
         |=> s_q.st == ST_IDLE && o_relay == $past(o_relay);
   endproperty
   a_stray: assert property (p_stray) else $error("stray byte acted on");

   property p_deselect;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_DESELECT
         |=> o_relay == 8'hff ##1 o_relay == ~(8'h01 << $past(i_rx_data[2:0], 2));
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect sequence wrong");

   property p_store;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_STORE
         |=> s_q.mem[$past(i_rx_data[3:0])] == $past(o_relay) && o_relay == $past(o_relay);
   endproperty
   a_store: assert property (p_store) else $error("pattern store wrong");

   property p_recall;
      take && s_q.st == ST_P1 && s_q.cmd == CMD_RECALL
         |=> o_relay == $past(s_q.mem[i_rx_data[3:0]]);
   endproperty
   a_recall: assert property (p_recall) else $error("pattern recall wrong");

   property p_timed_one;
      take && s_q.st == ST_P2 && s_q.cmd == CMD_TIMED_ONE && !s_q.relay[i_rx_data[2:0]]
         |=> o_busy && o_relay == ($past(o_relay) | (8'h01 << $past(i_rx_data[2:0])));
   endproperty
   a_timed_one: assert property (p_timed_one) else $error("timed relay start wrong");

   property p_pattern_start;
      take && s_q.st == ST_P3
         |=> o_busy && o_relay == $past(s_q.p2);
   endproperty
   a_pattern_start: assert property (p_pattern_start) else $error("start pattern wrong");

   property p_unsupported;
      take && s_q.st == ST_CMD && i_rx_data == CMD_UNSUPPORTED
         |=> s_q.st == ST_IDLE && o_relay == $past(o_relay) && !o_tx_valid;
   endproperty
   a_unsupported: assert property (p_unsupported) else $error("code 41 acted on");

endmodule : relay_pattern_command_engine
`default_nettype wire

// ### test/relay_host_model.sv
// host side model: frames relay commands and collects reply bytes
`timescale 1ns/100ps
`default_nettype none
module relay_host_model import relay_cmd_pkg::*; (
   // clock
   input wire logic i_clk,
   // byte stream to the engine
   output logic [7:0] o_rx_data,
   output logic o_rx_valid,
   // reply stream
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_valid
);
   localparam logic [7:0] BANK_STEER_CODE = 8'h0d;
   int echo_cnt = 0;
   logic [7:0] last_tx = 8'h00;
   initial begin
      o_rx_data = 8'h00;
      o_rx_valid = 1'b0;
   end
   always @(posedge i_clk) begin
      if (i_tx_valid === 1'b1) begin
         echo_cnt <= echo_cnt + 1;
         last_tx <= i_tx_data;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // whole bytes only; the data line shows the inverse once a byte is gone
   task send_byte(input logic [7:0] b);
      @(posedge i_clk);
      o_rx_data <= b;
      o_rx_valid <= 1'b1;
      @(posedge i_clk);
      o_rx_valid <= 1'b0;
      o_rx_data <= ~b;
   endtask : send_byte
   task cmd(input logic [7:0] code, p0, p1, p2, input int np);
      send_byte(PREFIX_BYTE);
      send_byte(BRANCH_BYTE);
      send_byte(code);
      if (np > 0) send_byte(p0);
      if (np > 1) send_byte(p1);
      if (np > 2) send_byte(p2);
   endtask : cmd
   // bank steering; the engine keeps no bank, so these bytes fall through as strays
   task steer_bank(input logic [7:0] bank);
      send_byte(PREFIX_BYTE);
      send_byte(BANK_STEER_CODE);
      send_byte(bank);
   endtask : steer_bank
   function automatic logic [7:0] time_byte(input logic fb, step, input logic [5:0] dur);
      return {fb, step, dur};
   endfunction : time_byte
endmodule : relay_host_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the relay pattern command engine
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import relay_cmd_pkg::*;
   localparam int TICK = 20;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] rx_data, tx_data, relay;
   logic rx_valid, tx_valid, busy;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, rd_val;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   int n, e;
   always #5 i_clk = ~i_clk;
   relay_pattern_command_engine #(.TICK_CYCLES(TICK)) uut (.i_clk(i_clk),
      .i_sys_rst(i_sys_rst), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
      .o_tx_data(tx_data), .o_tx_valid(tx_valid), .o_relay(relay), .o_busy(busy),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
   relay_host_model host (.i_clk(i_clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
      .i_tx_data(tx_data), .i_tx_valid(tx_valid));
   ////////////////////////////////////////////////////////////////////////////
   task summarize;
      $display("mismatches %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task chk(input string name, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task reg_read(input logic [7:0] a);
      @(posedge i_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : reg_read
   task run(input string name, input logic [7:0] code, p0, p1, p2, input int np,
            input logic [7:0] exp);
      host.cmd(code, p0, p1, p2, np);
      repeat (3) @(posedge i_clk);
      #1 chk(name, {24'h0, exp}, {24'h0, relay});
   endtask : run
   // counts cycles until the timer drops, never past the bound
   task timed(input int period);
      n = 0;
      while (busy === 1'b1 && n < period + 10) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("period", 1, 32'(n >= period - 4 && n <= period + 4));
   endtask : timed
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      #1 chk("relay_rst", 0, {24'h0, relay});
      host.steer_bank(8'h00);
      reg_read(REG_CTRL);
      chk("ctrl_rst", 1, rd_val);
      run("load", CMD_LOAD, 8'h13, 0, 0, 1, 8'h13);
      run("invert", CMD_INVERT, 0, 0, 0, 0, 8'hec);
      run("reverse", CMD_REVERSE, 0, 0, 0, 0, 8'h37);
      run("store", CMD_STORE, 8'h0f, 0, 0, 1, 8'h37);
      run("zero", CMD_LOAD, 8'h00, 0, 0, 1, 8'h00);
      run("recall", CMD_RECALL, 8'h0f, 0, 0, 1, 8'h37);
      run("recall_empty", CMD_RECALL, 8'h03, 0, 0, 1, 8'h00);
      run("select", CMD_SELECT, 8'h07, 0, 0, 1, 8'h80);
      run("deselect", CMD_DESELECT, 8'h00, 0, 0, 1, 8'hfe);
      run("toggle0", CMD_TOGGLE, 8'h00, 0, 0, 1, 8'hff);
      run("toggle3", CMD_TOGGLE, 8'h03, 0, 0, 1, 8'hf7);
      run("unsupported", CMD_UNSUPPORTED, 0, 0, 0, 0, 8'hf7);
      host.send_byte(CMD_LOAD);
      run("stray", CMD_LOAD - 8'h28, 0, 0, 0, -3, 8'hf7);
      e = host.echo_cnt;
      run("echo_relay", CMD_LINK_TEST, 0, 0, 0, 0, 8'hf7);
      chk("echo_cnt", e + 1, host.echo_cnt);
      chk("echo_byte", ECHO_BYTE, host.last_tx);
      reg_write(REG_CTRL, 0);
      run("disabled", CMD_LOAD, 8'h00, 0, 0, 1, 8'hf7);
      reg_write(REG_CTRL, 1);
      reg_read(8'h08);
      chk("unmapped", 0, rd_val);
      host.cmd(CMD_TIMED_ONE, host.time_byte(1, 0, 4), 8'h03, 0, 2);
      @(posedge i_clk);
      #1 chk("timed_on", 8'hff, relay);
      chk("busy", 1, busy);
      host.cmd(CMD_LOAD, 8'h00, 0, 0, 1);
      timed(5 * TICK - 9);
      repeat (2) @(posedge i_clk);
      #1 chk("timed_off", 8'hf7, relay);
      chk("feedback", e + 2, host.echo_cnt);
      run("already_on", CMD_TIMED_ONE, 8'h00, 8'h00, 0, 2, 8'hf7);
      chk("no_timer", 0, busy);
      host.cmd(CMD_TIMED_PATTERN, host.time_byte(0, 1, 1), 8'h0f, 8'hf0, 3);
      @(posedge i_clk);
      #1 chk("start_pat", 8'h0f, relay);
      reg_read(REG_STATUS);
      chk("status", 32'h10f, rd_val);
      timed(2 * (LONG_STEP_MS / BASE_STEP_MS) * TICK - 3);
      repeat (2) @(posedge i_clk);
      #1 chk("end_pat", 8'hf0, relay);
      chk("no_feedback", e + 2, host.echo_cnt);
      summarize();
   end
endmodule : testbench
`default_nettype wire
